// ===== verilog/exposure_setup_pkg.sv
// Constants for the exposure-loop status and sequencer setup register bank.
// Assumes one core clock and a host that reaches the bank over a four-wire serial port.
package exposure_setup_pkg;

  // Serial frame layout: address, direction bit, data word.
  localparam int unsigned ADDR_BITS = 9;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [4:0]  DIR_BIT_CNT  = 5'h09;
  localparam logic [4:0]  LAST_BIT_CNT = 5'h19;
  localparam logic        DIR_WRITE    = 1'h1;

  // Register addresses.
  localparam logic [8:0] ADDR_CALIB_A      = 9'h0B3;
  localparam logic [8:0] ADDR_CALIB_B      = 9'h0B4;
  localparam logic [8:0] ADDR_CALIB_C      = 9'h0B5;
  localparam logic [8:0] ADDR_COUNT_LOW    = 9'h0B8;
  localparam logic [8:0] ADDR_COUNT_HIGH   = 9'h0B9;
  localparam logic [8:0] ADDR_MEAN_LOCK    = 9'h0BA;
  localparam logic [8:0] ADDR_INTEG_RB     = 9'h0BB;
  localparam logic [8:0] ADDR_AMP_RB       = 9'h0BC;
  localparam logic [8:0] ADDR_RSVD_RO      = 9'h0BD;
  localparam logic [8:0] ADDR_SEQ_SETUP    = 9'h0C0;

  // Field positions.
  localparam int unsigned MEAN_LSB        = 0;
  localparam int unsigned MEAN_WIDTH      = 10;
  localparam int unsigned LOCK_BIT        = 12;
  localparam int unsigned COUNT_HIGH_W    = 3;
  localparam int unsigned AMP_FIRST_LSB   = 0;
  localparam int unsigned AMP_SECOND_LSB  = 2;
  localparam int unsigned DIGITAL_LSB     = 4;
  localparam int unsigned DIGITAL_WIDTH   = 12;
  localparam int unsigned CALIB_WIDTH     = 10;
  localparam int unsigned SETUP_RUN_BIT   = 0;
  localparam int unsigned SETUP_ROLL_BIT  = 1;
  localparam int unsigned SETUP_TRIG_BIT  = 4;
  localparam int unsigned SETUP_SLAVE_BIT = 5;

  // Reset values.
  localparam logic [9:0]  CALIB_A_RST = 10'h0AA;
  localparam logic [9:0]  CALIB_B_RST = 10'h100;
  localparam logic [9:0]  CALIB_C_RST = 10'h155;
  localparam logic        SETUP_BIT_RST = 1'h0;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic        SYNC_RST_LOW  = 1'h0;
  localparam logic        SYNC_RST_HIGH = 1'h1;

  // Serial engine phases.
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_DATA_RD,
    PH_DATA_WR,
    PH_DONE
  } phase_t;

endpackage

// ===== verilog/sync_two_flop.sv
// Two-flop level synchroniser for pins arriving from outside the core clock.
// Assumes the pin changes slowly compared with the core clock.
`timescale 1ns/1ps
module sync_two_flop #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // Only the second flop is visible outside; the first may be metastable.
  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // Both stages reset to the idle level of the pin.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule

// ===== verilog/exposure_setup_regs.sv
// Register bank: exposure-loop status readback and the first sequencer setup word.
// Assumes the host serial clock runs well below a quarter of the core clock,
// and that the exposure-loop status inputs are on the core clock.
`timescale 1ns/1ps
module exposure_setup_regs (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  input  wire logic [18:0] i_sampled_count,
  input  wire logic [9:0]  i_mean_level,
  input  wire logic        i_loop_locked,
  input  wire logic [15:0] i_applied_integration,
  input  wire logic [1:0]  i_analog_amp_first,
  input  wire logic [1:0]  i_analog_amp_second,
  input  wire logic [11:0] i_digital_amp,
  output logic             o_seq_run,
  output logic             o_rolling_shutter,
  output logic             o_triggered,
  output logic             o_slave_timing
);

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;

  // Every host pin is synchronised before the engine looks at it.
  sync_two_flop #(.RST_VAL(exposure_setup_pkg::SYNC_RST_LOW)) u_sync_sclk (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_spi_sclk),
    .o_sync     (sclk_s)
  );
  sync_two_flop #(.RST_VAL(exposure_setup_pkg::SYNC_RST_HIGH)) u_sync_cs (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_spi_cs_n),
    .o_sync     (cs_n_s)
  );
  sync_two_flop #(.RST_VAL(exposure_setup_pkg::SYNC_RST_LOW)) u_sync_mosi (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_spi_mosi),
    .o_sync     (mosi_s)
  );

  // Serial engine state.
  exposure_setup_pkg::phase_t phase_r;
  exposure_setup_pkg::phase_t phase_nxt;
  logic        sclk_d_r;
  logic        sclk_d_nxt;
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic [8:0]  addr_sh_r;
  logic [8:0]  addr_sh_nxt;
  logic [15:0] wr_sh_r;
  logic [15:0] wr_sh_nxt;
  logic [15:0] rd_sh_r;
  logic [15:0] rd_sh_nxt;
  logic        miso_r;
  logic        miso_nxt;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        ld_read;
  logic        wr_commit;
  logic [15:0] wr_word;
  logic [15:0] rd_word;

  // Setup state.
  logic       run_r;
  logic       run_nxt;
  logic       roll_r;
  logic       roll_nxt;
  logic       trig_r;
  logic       trig_nxt;
  logic       slave_r;
  logic       slave_nxt;
  logic       trig_eff_r;
  logic       trig_eff_nxt;
  logic       slave_eff_r;
  logic       slave_eff_nxt;
  logic [9:0] calib_a_r;
  logic [9:0] calib_a_nxt;
  logic [9:0] calib_b_r;
  logic [9:0] calib_b_nxt;
  logic [9:0] calib_c_r;
  logic [9:0] calib_c_nxt;

  // Edges of the synchronised serial clock; both read the second flop only.
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign wr_word   = {wr_sh_r[14:0], mosi_s};

  // Read multiplexer; status is sampled at the moment the direction bit arrives.
  // Unmapped and reserved read-only addresses return zero.
  always_comb begin
    rd_word = exposure_setup_pkg::WORD_ZERO;
    case (addr_sh_r)
      exposure_setup_pkg::ADDR_CALIB_A: begin
        rd_word[exposure_setup_pkg::CALIB_WIDTH-1:0] = calib_a_r;
      end
      exposure_setup_pkg::ADDR_CALIB_B: begin
        rd_word[exposure_setup_pkg::CALIB_WIDTH-1:0] = calib_b_r;
      end
      exposure_setup_pkg::ADDR_CALIB_C: begin
        rd_word[exposure_setup_pkg::CALIB_WIDTH-1:0] = calib_c_r;
      end
      exposure_setup_pkg::ADDR_COUNT_LOW: begin
        rd_word = i_sampled_count[15:0];
      end
      exposure_setup_pkg::ADDR_COUNT_HIGH: begin
        rd_word[exposure_setup_pkg::COUNT_HIGH_W-1:0] = i_sampled_count[18:16];
      end
      exposure_setup_pkg::ADDR_MEAN_LOCK: begin
        rd_word[exposure_setup_pkg::MEAN_WIDTH-1:exposure_setup_pkg::MEAN_LSB] =
          i_mean_level;
        rd_word[exposure_setup_pkg::LOCK_BIT] = i_loop_locked;
      end
      exposure_setup_pkg::ADDR_INTEG_RB: begin
        rd_word = i_applied_integration;
      end
      exposure_setup_pkg::ADDR_AMP_RB: begin
        rd_word[exposure_setup_pkg::AMP_FIRST_LSB +: 2]  = i_analog_amp_first;
        rd_word[exposure_setup_pkg::AMP_SECOND_LSB +: 2] = i_analog_amp_second;
        rd_word[exposure_setup_pkg::DIGITAL_LSB +: exposure_setup_pkg::DIGITAL_WIDTH] =
          i_digital_amp;
      end
      exposure_setup_pkg::ADDR_SEQ_SETUP: begin
        rd_word[exposure_setup_pkg::SETUP_RUN_BIT]   = run_r;
        rd_word[exposure_setup_pkg::SETUP_ROLL_BIT]  = roll_r;
        rd_word[exposure_setup_pkg::SETUP_TRIG_BIT]  = trig_r;
        rd_word[exposure_setup_pkg::SETUP_SLAVE_BIT] = slave_r;
      end
      default: begin
        rd_word = exposure_setup_pkg::WORD_ZERO;
      end
    endcase
  end

  // Serial engine: address shifts in on rising edges, then one direction bit,
  // then sixteen data bits. Read data leaves on falling edges, MSB first.
  always_comb begin
    phase_nxt   = phase_r;
    sclk_d_nxt  = sclk_s;
    bit_cnt_nxt = bit_cnt_r;
    addr_sh_nxt = addr_sh_r;
    wr_sh_nxt   = wr_sh_r;
    rd_sh_nxt   = rd_sh_r;
    miso_nxt    = miso_r;
    ld_read     = 1'h0;
    wr_commit   = 1'h0;
    if (cs_n_s) begin
      // Deselect aborts any partial frame, so a short frame never writes.
      phase_nxt   = exposure_setup_pkg::PH_ADDR;
      bit_cnt_nxt = 5'h00;
      miso_nxt    = 1'h0;
    end else if (sclk_rise) begin
      bit_cnt_nxt = 5'(bit_cnt_r + 5'h01);
      case (phase_r)
        exposure_setup_pkg::PH_ADDR: begin
          if (bit_cnt_r == exposure_setup_pkg::DIR_BIT_CNT) begin
            if (mosi_s == exposure_setup_pkg::DIR_WRITE) begin
              phase_nxt = exposure_setup_pkg::PH_DATA_WR;
            end else begin
              phase_nxt = exposure_setup_pkg::PH_DATA_RD;
              rd_sh_nxt = rd_word;
              ld_read   = 1'h1;
            end
          end else begin
            addr_sh_nxt = {addr_sh_r[7:0], mosi_s};
          end
        end
        exposure_setup_pkg::PH_DATA_WR: begin
          wr_sh_nxt = wr_word;
          if (bit_cnt_r == exposure_setup_pkg::LAST_BIT_CNT) begin
            wr_commit = 1'h1;
            phase_nxt = exposure_setup_pkg::PH_DONE;
          end
        end
        exposure_setup_pkg::PH_DATA_RD: begin
          if (bit_cnt_r == exposure_setup_pkg::LAST_BIT_CNT) begin
            phase_nxt = exposure_setup_pkg::PH_DONE;
          end
        end
        exposure_setup_pkg::PH_DONE: begin
          // Surplus clocks after a full frame are ignored.
          bit_cnt_nxt = bit_cnt_r;
        end
        default: begin
          phase_nxt = exposure_setup_pkg::PH_ADDR;
        end
      endcase
    end else if (sclk_fall && phase_r == exposure_setup_pkg::PH_DATA_RD) begin
      miso_nxt  = rd_sh_r[15];
      rd_sh_nxt = {rd_sh_r[14:0], 1'h0};
    end
  end

  // Serial engine registers.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r   <= exposure_setup_pkg::PH_ADDR;
      sclk_d_r  <= 1'h0;
      bit_cnt_r <= 5'h00;
      addr_sh_r <= 9'h000;
      wr_sh_r   <= 16'h0000;
      rd_sh_r   <= 16'h0000;
      miso_r    <= 1'h0;
    end else begin
      phase_r   <= phase_nxt;
      sclk_d_r  <= sclk_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      addr_sh_r <= addr_sh_nxt;
      wr_sh_r   <= wr_sh_nxt;
      rd_sh_r   <= rd_sh_nxt;
      miso_r    <= miso_nxt;
    end
  end

  // Setup writes. The gated mode outputs are registered from the next values,
  // so each output is a flop yet follows the stored bits with no extra lag.
  always_comb begin
    run_nxt     = run_r;
    roll_nxt    = roll_r;
    trig_nxt    = trig_r;
    slave_nxt   = slave_r;
    calib_a_nxt = calib_a_r;
    calib_b_nxt = calib_b_r;
    calib_c_nxt = calib_c_r;
    if (wr_commit) begin
      case (addr_sh_r)
        exposure_setup_pkg::ADDR_SEQ_SETUP: begin
          run_nxt   = wr_word[exposure_setup_pkg::SETUP_RUN_BIT];
          roll_nxt  = wr_word[exposure_setup_pkg::SETUP_ROLL_BIT];
          trig_nxt  = wr_word[exposure_setup_pkg::SETUP_TRIG_BIT];
          slave_nxt = wr_word[exposure_setup_pkg::SETUP_SLAVE_BIT];
        end
        exposure_setup_pkg::ADDR_CALIB_A: begin
          calib_a_nxt = wr_word[exposure_setup_pkg::CALIB_WIDTH-1:0];
        end
        exposure_setup_pkg::ADDR_CALIB_B: begin
          calib_b_nxt = wr_word[exposure_setup_pkg::CALIB_WIDTH-1:0];
        end
        exposure_setup_pkg::ADDR_CALIB_C: begin
          calib_c_nxt = wr_word[exposure_setup_pkg::CALIB_WIDTH-1:0];
        end
        default: begin
          // Read-only and unmapped addresses swallow the write.
          run_nxt = run_r;
        end
      endcase
    end
    trig_eff_nxt  = trig_nxt & ~roll_nxt;
    slave_eff_nxt = slave_nxt & ~roll_nxt;
  end

  // Setup registers; the sequencer comes out of reset idle.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_r       <= exposure_setup_pkg::SETUP_BIT_RST;
      roll_r      <= exposure_setup_pkg::SETUP_BIT_RST;
      trig_r      <= exposure_setup_pkg::SETUP_BIT_RST;
      slave_r     <= exposure_setup_pkg::SETUP_BIT_RST;
      trig_eff_r  <= exposure_setup_pkg::SETUP_BIT_RST;
      slave_eff_r <= exposure_setup_pkg::SETUP_BIT_RST;
      calib_a_r   <= exposure_setup_pkg::CALIB_A_RST;
      calib_b_r   <= exposure_setup_pkg::CALIB_B_RST;
      calib_c_r   <= exposure_setup_pkg::CALIB_C_RST;
    end else begin
      run_r       <= run_nxt;
      roll_r      <= roll_nxt;
      trig_r      <= trig_nxt;
      slave_r     <= slave_nxt;
      trig_eff_r  <= trig_eff_nxt;
      slave_eff_r <= slave_eff_nxt;
      calib_a_r   <= calib_a_nxt;
      calib_b_r   <= calib_b_nxt;
      calib_c_r   <= calib_c_nxt;
    end
  end

  // Outputs come straight from flops.
  assign o_spi_miso        = miso_r;
  assign o_seq_run         = run_r;
  assign o_rolling_shutter = roll_r;
  assign o_triggered       = trig_eff_r;
  assign o_slave_timing    = slave_eff_r;

  // Checks on the register bank.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_COUNT_LOW: assert property (
    ld_read && addr_sh_r == exposure_setup_pkg::ADDR_COUNT_LOW
      |=> rd_sh_r == $past(i_sampled_count[15:0]))
    else $error("Low count word does not match the sampled count.");

  AST_COUNT_HIGH: assert property (
    ld_read && addr_sh_r == exposure_setup_pkg::ADDR_COUNT_HIGH
      |=> rd_sh_r == {13'h0000, $past(i_sampled_count[18:16])})
    else $error("High count word does not hold the upper three bits.");

  AST_MEAN_LOCK: assert property (
    ld_read && addr_sh_r == exposure_setup_pkg::ADDR_MEAN_LOCK
      |=> rd_sh_r[9:0] == $past(i_mean_level) && rd_sh_r[12] == $past(i_loop_locked)
          && rd_sh_r[15:13] == 3'h0 && rd_sh_r[11:10] == 2'h0)
    else $error("Mean level or lock flag misplaced.");

  AST_AMP_READ: assert property (
    ld_read && addr_sh_r == exposure_setup_pkg::ADDR_AMP_RB
      |=> rd_sh_r == {$past(i_digital_amp), $past(i_analog_amp_second),
                      $past(i_analog_amp_first)})
    else $error("Gain readback fields misplaced.");

  AST_RUN_WRITE: assert property (
    wr_commit && addr_sh_r == exposure_setup_pkg::ADDR_SEQ_SETUP
      |=> o_seq_run == $past(wr_word[0]))
    else $error("Run bit did not follow the setup write.");

  AST_RUN_HOLD: assert property (
    !wr_commit |=> $stable(o_seq_run))
    else $error("Run bit changed without a write.");

  AST_ROLL_WRITE: assert property (
    wr_commit && addr_sh_r == exposure_setup_pkg::ADDR_SEQ_SETUP
      |=> o_rolling_shutter == $past(wr_word[1]))
    else $error("Shutter selection did not follow the setup write.");

  AST_TRIG_GLOBAL: assert property (
    wr_commit && addr_sh_r == exposure_setup_pkg::ADDR_SEQ_SETUP
      |=> o_triggered == ($past(wr_word[4]) && !$past(wr_word[1])))
    else $error("Triggered mode not gated by global shutter.");

  AST_SLAVE_GLOBAL: assert property (
    o_rolling_shutter |-> !o_slave_timing && !o_triggered)
    else $error("Slave or triggered timing active in rolling shutter.");

  COV_STATUS_READ: cover property (
    ld_read && addr_sh_r == exposure_setup_pkg::ADDR_MEAN_LOCK ##[1:600]
      phase_r == exposure_setup_pkg::PH_DONE);
  COV_RUN_ON: cover property ($rose(o_seq_run));
  COV_TRIG_ON: cover property ($rose(o_triggered));
  COV_ROLL_MASK: cover property (trig_r && o_rolling_shutter && !o_triggered);

endmodule

// ===== testbench/spi_host_model.sv
// Host controller model that drives the four-wire serial port of the register bank.
// Assumes mode 0 framing: 9 address bits, a direction bit and 16 data bits, MSB first.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_spi_miso,
  output logic      o_spi_sclk,
  output logic      o_spi_cs_n,
  output logic      o_spi_mosi
);
  // Each serial half period spans five core clocks, above the three the bank needs.
  localparam int HALF = 5;

  // The link rests deselected with its clock low.
  initial begin
    o_spi_sclk = 1'h0;
    o_spi_cs_n = 1'h1;
    o_spi_mosi = 1'h0;
  end

  // One frame; nbits below 26 cuts it short, which the bank must ignore.
  task automatic xfer(input logic [8:0] addr, input logic wr, input logic [15:0] wd,
                      input int nbits, output logic [15:0] rd);
    logic [15:0] wmask;
    logic [25:0] frame;
    wmask = (wr && addr == 9'h0C0) ? 16'h0033 : 16'hFFFF; // Undefined setup bits stay 0.
    frame = {addr, wr, wd & wmask};
    rd = 16'h0000;
    @(negedge i_core_clk);
    o_spi_cs_n = 1'h0;
    for (int i = 0; i < nbits; i++) begin
      o_spi_mosi = frame[25-i];
      repeat (HALF) @(negedge i_core_clk);
      o_spi_sclk = 1'h1;
      if (i >= 10) begin
        rd = {rd[14:0], i_spi_miso};
      end
      repeat (HALF) @(negedge i_core_clk);
      o_spi_sclk = 1'h0;
    end
    repeat (HALF) @(negedge i_core_clk);
    o_spi_cs_n = 1'h1;
    // A released data line must not keep looking valid.
    o_spi_mosi = ~o_spi_mosi;
    repeat (HALF) @(negedge i_core_clk);
  endtask
endmodule

// ===== testbench/exposure_loop_status_and_sequencer_setup_test.sv
// Self-checking bench for the exposure status and sequencer setup register bank.
// Assumes the host model above and a 10 MHz core clock; status is driven on falling edges.
`timescale 1ns/1ps
module exposure_loop_status_and_sequencer_setup_test;
  logic        i_core_clk;
  logic        i_rst;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic [18:0] cnt;
  logic [9:0]  mean;
  logic        lock;
  logic [15:0] integ;
  logic [1:0]  amp1;
  logic [1:0]  amp2;
  logic [11:0] dig;
  logic        run;
  logic        roll;
  logic        trig;
  logic        slave;
  logic [15:0] rd;
  logic [31:0] seed;
  int          n_mismatch;
  int          num_checks;
  int          setup_m;
  logic [8:0]  addrs [11] = '{9'h0B3, 9'h0B4, 9'h0B5, 9'h0B8, 9'h0B9, 9'h0BA, 9'h0BB,
                              9'h0BC, 9'h0BD, 9'h0BE, 9'h0C0};

  exposure_setup_regs exposure_setup_regs_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .i_sampled_count(cnt), .i_mean_level(mean),
    .i_loop_locked(lock), .i_applied_integration(integ), .i_analog_amp_first(amp1),
    .i_analog_amp_second(amp2), .i_digital_amp(dig), .o_seq_run(run),
    .o_rolling_shutter(roll), .o_triggered(trig), .o_slave_timing(slave));

  spi_host_model spi_host_model_inst (
    .i_core_clk(i_core_clk), .i_spi_miso(miso), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n),
    .o_spi_mosi(mosi));

  // Free-running core clock, 100 ns period.
  initial i_core_clk = 1'h0;
  always #50 i_core_clk = ~i_core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'h0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  // Reference model of every readable word, from the status the bench drives.
  function automatic logic [15:0] model_read(input logic [8:0] a);
    case (a)
      9'h0B3:  return 16'h00AA;
      9'h0B4:  return 16'h0100;
      9'h0B5:  return 16'h0155;
      9'h0B8:  return cnt[15:0];
      9'h0B9:  return {13'h0000, cnt[18:16]};
      9'h0BA:  return {3'h0, lock, 2'h0, mean};
      9'h0BB:  return integ;
      9'h0BC:  return {dig, amp2, amp1};
      9'h0C0:  return 16'(setup_m);
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [8:0] a);
    spi_host_model_inst.xfer(a, 1'h0, 16'h0000, 26, rd);
    check(rd, model_read(a));
  endtask

  // Only a complete write frame to the setup word changes the model.
  task automatic wr(input logic [8:0] a, input logic [15:0] d, input int nb);
    spi_host_model_inst.xfer(a, 1'h1, d, nb, rd);
    if (nb == 26 && a == 9'h0C0) begin
      setup_m = int'(d & 16'h0033);
    end
  endtask

  // Trigger and slave selections only reach the sequencer in global shutter.
  task automatic chk_modes();
    logic [3:0] em;
    em = {setup_m[5] & ~setup_m[1], setup_m[4] & ~setup_m[1], setup_m[1], setup_m[0]};
    check({12'h000, slave, trig, roll, run}, {12'h000, em});
  endtask

  task automatic new_status();
    @(negedge i_core_clk);
    seed = lfsr(seed);
    cnt = seed[18:0];
    mean = seed[28:19];
    lock = seed[29];
    seed = lfsr(seed);
    integ = seed[15:0];
    {dig, amp2, amp1} = seed[31:16];
  endtask

  task automatic do_reset();
    @(negedge i_core_clk);
    i_rst = 1'h1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'h0;
    setup_m = 0;
    repeat (4) @(negedge i_core_clk);
  endtask

  // Hang guard: the whole run fits well inside this many core clocks.
  initial begin
    for (int c = 0; c < 100000; c++) begin
      @(posedge i_core_clk);
    end
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {cnt, mean, lock, integ, amp1, amp2, dig} = '0;
    i_rst = 1'h1;
    n_mismatch = 0;
    num_checks = 0;
    setup_m = 0;
    seed = 32'hE231;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'h0;
    repeat (4) @(negedge i_core_clk);
    // Reset values of every word, an unmapped address among them.
    chk_modes();
    foreach (addrs[i]) rd_chk(addrs[i]);
    // Random status words, read back field by field.
    for (int k = 0; k < 6; k++) begin
      new_status();
      for (int j = 3; j < 8; j++) rd_chk(addrs[j]);
    end
    // Writes to read-only words must leave them showing live status, or zero for the reserved word.
    wr(9'h0B8, 16'hFFFF, 26);
    wr(9'h0BD, 16'h0000, 26); // The reserved word is only ever given its default.
    rd_chk(9'h0B8);
    rd_chk(9'h0BD);
    // Every combination of the four setup bits; the host model clears the noise on the others.
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      wr(9'h0C0, {seed[15:6], k[3:2], seed[3:2], k[1:0]}, 26);
      chk_modes();
      rd_chk(9'h0C0);
    end
    // A frame cut one bit short must not touch the setup word.
    wr(9'h0C0, 16'h0000, 25);
    chk_modes();
    rd_chk(9'h0C0);
    // A second reset in mid-run returns the sequencer to idle.
    do_reset();
    chk_modes();
    rd_chk(9'h0C0);
    wrap_up();
  end
endmodule
